// file: hw/pbd_pkg.sv
// Purpose: constants for the peripheral base decode block
// Assumes: 32-bit internal address, control space selects the base registers
// Notes:   bit positions follow the base register layouts
package pbd_pkg;
    localparam int          ADDR_W         = 32;
    localparam logic [11:0] CTL_PRIMARY    = 12'hC0F;  // control space of primary base
    localparam logic [11:0] CTL_SECONDARY  = 12'hC0E;  // control space of secondary base
    localparam int          PRI_BA_HI      = 31;
    localparam int          PRI_BA_LO      = 12;
    localparam int          PRI_WP_BIT     = 8;
    localparam int          PRI_AM_BIT     = 6;
    localparam int          PRI_CI_BIT     = 5;
    localparam int          PRI_SC_BIT     = 4;
    localparam int          PRI_SD_BIT     = 3;
    localparam int          PRI_UC_BIT     = 2;
    localparam int          PRI_UD_BIT     = 1;
    localparam int          VALID_BIT      = 0;
    localparam int          SEC_BA_HI      = 31;
    localparam int          SEC_BA_LO      = 30;
    localparam int          SEC_LS_HI      = 7;
    localparam int          SEC_LS_LO      = 1;
    localparam int          LEVELS         = 7;
    localparam logic [31:0] PRI_WR_MASK    = 32'hFFFF_F17F;  // implemented bits of primary
    localparam logic [31:0] SEC_WR_MASK    = 32'hC000_00FF;  // implemented bits of secondary
    localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;
    localparam logic [2:0]  LVL_NONE       = 3'h0;
    // access space presented with each cycle
    typedef enum logic [2:0] {
        PBD_SP_USER_DATA  = 3'b001,
        PBD_SP_USER_CODE  = 3'b010,
        PBD_SP_SUPER_DATA = 3'b101,
        PBD_SP_SUPER_CODE = 3'b110,
        PBD_SP_CPU        = 3'b111
    } pbd_space_e;
endpackage

// file: hw/pbd_attr_check.sv
// Purpose: attribute mask check for the primary window
// Assumes: space and master attributes are stable with the address
// Notes:   pure combinational, one instance in the decoder
`timescale 1ns/1ps
module pbd_attr_check (
    input  wire pbd_pkg::pbd_space_e space_i,
    input  wire logic                alt_master_i,
    input  wire logic                write_i,
    input  wire logic                wp_i,
    input  wire logic                alt_master_mask_i,
    input  wire logic                cpu_space_mask_i,
    input  wire logic                super_code_mask_i,
    input  wire logic                super_data_mask_i,
    input  wire logic                user_code_mask_i,
    input  wire logic                user_data_mask_i,
    output wire logic                blocked_o
);
    import pbd_pkg::*;
    wire logic sc_hit;
    wire logic sd_hit;
    wire logic uc_hit;
    wire logic ud_hit;
    wire logic space_blk;
    wire logic ci_blk;
    wire logic am_blk;
    wire logic wp_blk;
    // per-space masks
    assign sc_hit    = (space_i == PBD_SP_SUPER_CODE) && super_code_mask_i;
    assign sd_hit    = (space_i == PBD_SP_SUPER_DATA) && super_data_mask_i;
    assign uc_hit    = (space_i == PBD_SP_USER_CODE)  && user_code_mask_i;
    assign ud_hit    = (space_i == PBD_SP_USER_DATA)  && user_data_mask_i;
    // alternate master with its mask clear skips the space masks
    assign space_blk = (sc_hit | sd_hit | uc_hit | ud_hit) & ~alt_master_i;
    assign ci_blk    = (space_i == PBD_SP_CPU) && cpu_space_mask_i;
    assign am_blk    = alt_master_i && alt_master_mask_i;
    assign wp_blk    = write_i && wp_i;
    assign blocked_o = space_blk | ci_blk | am_blk | wp_blk;
endmodule

// file: hw/pbd_decode.sv
// Purpose: relocatable base decode for the two peripheral windows
// Assumes: control writes come from a supervisor move-to-control cycle
// Notes:   base registers read back only on the debug port
`timescale 1ns/1ps
module pbd_decode #(
    parameter int PRI_WIN_BITS = 12
) (
    input  wire logic                       mclk_i,
    input  wire logic                       rst_i,
    // control space write port
    input  wire logic                       ctl_wr_i,
    input  wire logic [11:0]                ctl_sel_i,
    input  wire logic [31:0]                ctl_wdata_i,
    // debug readback
    input  wire logic                       dbg_rd_i,
    input  wire logic                       dbg_sel_sec_i,
    output wire logic [31:0]                dbg_rdata_o,
    // access under decode
    input  wire logic [pbd_pkg::ADDR_W-1:0] addr_i,
    input  wire pbd_pkg::pbd_space_e        space_i,
    input  wire logic                       write_i,
    input  wire logic                       alt_master_i,
    input  wire logic                       sram_hit_i,
    output wire logic                       sram_sel_o,
    output wire logic                       pri_sel_o,
    output wire logic                       sec_sel_o,
    output wire logic                       ext_sel_o,
    // interrupt arbitration
    input  wire logic [2:0]                 pri_level_i,
    input  wire logic [2:0]                 sec_level_i,
    output wire logic                       sec_wins_o
);
    import pbd_pkg::*;

    // limitations worth knowing before integration:
    // - the base registers have no software read path; only the debug
    //   port sees them, so firmware must keep its own copy
    // - unimplemented bits are dropped on write and read back as zero
    // - a new base takes effect on the cycle after the control write, so
    //   an access issued in the same cycle still decodes the old base
    // - selects are combinational from address and attributes; the core
    //   must hold them stable for the whole decode cycle
    // - only the valid and level bits matter at reset, but every bit is cleared so
    //   that a debug read after reset never shows unknown values

    // elaboration check: window at least 4 KB and no coarser than the secondary grain
    if (PRI_WIN_BITS < PRI_BA_LO || PRI_WIN_BITS > SEC_BA_LO) begin : g_bad_win
        $error("PRI_WIN_BITS out of range");
    end
    // the level inputs are three bits wide, so only levels 1 to 7 exist
    if (LEVELS != 7) begin : g_bad_levels
        $error("level count must match the three-bit level inputs");
    end

    ////////////////////////////////////////////////////////////////////////////
    // base registers
    // both registers are write-only from the core; a write to any other
    // control space number is ignored here and left to its own owner
    logic [31:0]       pri_q;
    logic [31:0]       pri_d;
    logic [31:0]       sec_q;
    logic [31:0]       sec_d;
    logic [31:0]       dbg_q;
    logic [31:0]       dbg_d;
    wire  logic        wr_pri;
    wire  logic        wr_sec;
    wire  logic [31:0] pri_kept;
    wire  logic [31:0] sec_kept;

    // strip bits that have no storage so readback never shows noise
    assign pri_kept = ctl_wdata_i & PRI_WR_MASK;
    assign sec_kept = ctl_wdata_i & SEC_WR_MASK;
    assign wr_pri   = ctl_wr_i && (ctl_sel_i == CTL_PRIMARY);
    assign wr_sec   = ctl_wr_i && (ctl_sel_i == CTL_SECONDARY);
    assign pri_d    = wr_pri ? pri_kept : pri_q;
    assign sec_d    = wr_sec ? sec_kept : sec_q;
    // debug picks one register and holds it until the next debug read
    assign dbg_d    = dbg_rd_i ? (dbg_sel_sec_i ? sec_q : pri_q) : dbg_q;

    // reset clears both registers whole, valid and level bits included
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pri_q <= ZERO_WORD;
            sec_q <= ZERO_WORD;
        end else begin
            pri_q <= pri_d;
            sec_q <= sec_d;
        end
    end

    // debug readback is registered, one cycle after the read strobe
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            dbg_q <= ZERO_WORD;
        end else begin
            dbg_q <= dbg_d;
        end
    end
    assign dbg_rdata_o = dbg_q;

    ////////////////////////////////////////////////////////////////////////////
    // window matching
    // the primary compare grain is a parameter so a larger window can be
    // carved without touching the register layout; the base field keeps
    // its bit positions and the low base bits simply go unused
    wire logic pri_valid;
    wire logic sec_valid;
    wire logic pri_addr_hit;
    wire logic sec_field_hit;
    wire logic sec_addr_hit;
    wire logic attr_blk;

    // upper-field compare shared by both windows; lo sets the grain
    function automatic logic field_match(input logic [31:0] a,
                                         input logic [31:0] b,
                                         input int          lo);
        logic [31:0] keep;
        keep = ZERO_WORD;
        for (int k = 0; k < ADDR_W; k++) begin
            keep[k] = (k >= lo);
        end
        return ((a ^ b) & keep) == ZERO_WORD;
    endfunction

    assign pri_valid     = pri_q[VALID_BIT];
    assign sec_valid     = sec_q[VALID_BIT];
    // window may be widened above 4 KB by the parameter
    assign pri_addr_hit  = field_match(addr_i, pri_q, PRI_WIN_BITS);
    // two-bit compare gives 1024 MB granularity
    assign sec_field_hit = field_match(addr_i, sec_q, SEC_BA_LO);
    // an invalid secondary base must not shadow anything below it
    assign sec_addr_hit  = sec_valid && sec_field_hit;

    pbd_attr_check u_attr (
        .space_i           (space_i),
        .alt_master_i      (alt_master_i),
        .write_i           (write_i),
        .wp_i              (pri_q[PRI_WP_BIT]),
        .alt_master_mask_i (pri_q[PRI_AM_BIT]),
        .cpu_space_mask_i  (pri_q[PRI_CI_BIT]),
        .super_code_mask_i (pri_q[PRI_SC_BIT]),
        .super_data_mask_i (pri_q[PRI_SD_BIT]),
        .user_code_mask_i  (pri_q[PRI_UC_BIT]),
        .user_data_mask_i  (pri_q[PRI_UD_BIT]),
        .blocked_o         (attr_blk)
    );

    ////////////////////////////////////////////////////////////////////////////
    // priority chain: sram, secondary, primary, external
    // each stage sees only what the stages above it left over, so at most
    // one select is high; a secondary base that overlaps the primary one
    // wins, since the whole 1024 MB region belongs to it
    wire logic left_after_sram;
    wire logic left_after_sec;
    wire logic pri_take;

    assign left_after_sram = ~sram_hit_i;
    assign left_after_sec  = left_after_sram && ~sec_addr_hit;
    // a masked attribute is a plain miss, never an error response
    assign pri_take        = pri_valid && pri_addr_hit && ~attr_blk;

    assign sram_sel_o = sram_hit_i;
    assign sec_sel_o  = left_after_sram && sec_addr_hit;
    assign pri_sel_o  = left_after_sec && pri_take;
    assign ext_sel_o  = left_after_sec && ~pri_take;

    ////////////////////////////////////////////////////////////////////////////
    // interrupt level tie-break
    // level zero means nothing pending, so it never counts as a tie;
    // outside a tie the level bits are not consulted and the higher level
    // wins, which keeps the arbitration predictable for software
    wire logic [LEVELS:1] lvl_sel;
    wire logic [LEVELS:1] tie_at;
    wire logic            same_lvl;

    assign lvl_sel  = sec_q[SEC_LS_HI:SEC_LS_LO];
    assign same_lvl = (pri_level_i == sec_level_i) && (pri_level_i != LVL_NONE);
    // one-hot tie vector so no index reaches outside the level bits
    for (genvar g = 1; g <= LEVELS; g++) begin : g_tie
        assign tie_at[g] = same_lvl && (pri_level_i == 3'(g));
    end
    assign sec_wins_o = same_lvl ? |(tie_at & lvl_sel) :
                        (sec_level_i > pri_level_i);
endmodule

// file: sim/pbd_decode_sva.sv
// Purpose: port assertions for the peripheral base decode
// Assumes: shadow bases follow the control writes exactly
// Notes:   space masks are checked for the core only here
`timescale 1ns/1ps
module pbd_decode_sva #(parameter int PRI_WIN_BITS = 12) (
    input wire logic                mclk_i, rst_i, ctl_wr_i, dbg_rd_i, dbg_sel_sec_i,
    input wire logic                write_i, alt_master_i, sram_hit_i, sec_wins_o,
    input wire logic                sram_sel_o, pri_sel_o, sec_sel_o, ext_sel_o,
    input wire logic [11:0]         ctl_sel_i,
    input wire logic [31:0]         ctl_wdata_i, dbg_rdata_o, addr_i,
    input wire logic [2:0]          pri_level_i, sec_level_i,
    input wire pbd_pkg::pbd_space_e space_i
);
    import pbd_pkg::*;
    logic [31:0] pri_q, sec_q;
    // shadow copies; unimplemented bits dropped so readback compares whole words
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pri_q <= ZERO_WORD;
            sec_q <= ZERO_WORD;
        end else if (ctl_wr_i && ctl_sel_i == CTL_PRIMARY) begin
            pri_q <= ctl_wdata_i & PRI_WR_MASK;
        end else if (ctl_wr_i && ctl_sel_i == CTL_SECONDARY) begin
            sec_q <= ctl_wdata_i & SEC_WR_MASK;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    AST_SEC_HIT: assert property (sec_sel_o == (!sram_hit_i && sec_q[VALID_BIT]
        && addr_i[SEC_BA_HI:SEC_BA_LO] == sec_q[SEC_BA_HI:SEC_BA_LO])) else $error("secondary hit");
    AST_PRI_BASE: assert property (pri_sel_o |-> pri_q[VALID_BIT]
        && addr_i[31:PRI_WIN_BITS] == pri_q[31:PRI_WIN_BITS]) else $error("primary base");
    AST_WP: assert property (pri_sel_o && write_i |-> !pri_q[PRI_WP_BIT])
        else $error("write protect");
    AST_ALT: assert property (pri_sel_o && alt_master_i |-> !pri_q[PRI_AM_BIT])
        else $error("alternate master mask");
    AST_SPACE: assert property (pri_sel_o && !alt_master_i |-> !pri_q[space_i == PBD_SP_SUPER_CODE ?
        PRI_SC_BIT : space_i == PBD_SP_SUPER_DATA ? PRI_SD_BIT : space_i == PBD_SP_USER_CODE ?
        PRI_UC_BIT : space_i == PBD_SP_USER_DATA ? PRI_UD_BIT : 9]) else $error("space mask");
    AST_CPU: assert property (pri_sel_o && space_i == PBD_SP_CPU |-> !pri_q[PRI_CI_BIT])
        else $error("cpu space mask");
    AST_TIE: assert property (pri_level_i == sec_level_i && pri_level_i != LVL_NONE
        |-> sec_wins_o == sec_q[pri_level_i]) else $error("level tie");
    AST_DBG: assert property (dbg_rd_i |=> dbg_rdata_o == ($past(dbg_sel_sec_i)
        ? $past(sec_q) : $past(pri_q))) else $error("debug readback");
    AST_EXT: assert property (ext_sel_o == (!sram_sel_o && !sec_sel_o && !pri_sel_o))
        else $error("external select");
    COV_PRI: cover property (pri_sel_o);
    COV_ALT: cover property (pri_sel_o && alt_master_i && space_i == PBD_SP_SUPER_CODE);
    COV_SEC: cover property (sec_sel_o && pri_q[VALID_BIT]);
    COV_WIN: cover property (sec_wins_o);
endmodule
bind pbd_decode pbd_decode_sva #(.PRI_WIN_BITS(PRI_WIN_BITS)) pbd_decode_sva_i (.*);

// file: sim/pbd_cpu_model.sv
// Purpose: supervisor core writing the bases and debug port reading them
// Assumes: one-cycle strobes, raised just after a rising edge
// Notes:   released write data shows its inverse, never the old word
`timescale 1ns/1ps
module pbd_cpu_model (
    input  wire logic        mclk_i,
    output logic             ctl_wr_o = 1'b0,
    output logic [11:0]      ctl_sel_o = 12'h000,
    output logic [31:0]      ctl_wdata_o = 32'h0000_0000,
    output logic             dbg_rd_o = 1'b0,
    output logic             dbg_sel_o = 1'b0,
    input  wire logic [31:0] dbg_rdata_i
);
    // move-to-control write of a whole word, taken at the next edge
    task ctl_write(input logic [11:0] sel, input logic [31:0] data);
        @(posedge mclk_i) #1;
        {ctl_wr_o, ctl_sel_o, ctl_wdata_o} = {1'b1, sel, data};
        @(posedge mclk_i) #1;
        {ctl_wr_o, ctl_wdata_o} = {1'b0, ~data};
    endtask
    // background debug read, data settled one cycle later
    task dbg_read(input logic sec, output logic [31:0] data);
        @(posedge mclk_i) #1;
        {dbg_rd_o, dbg_sel_o} = {1'b1, sec};
        @(posedge mclk_i) #1;
        dbg_rd_o = 1'b0;
        data = dbg_rdata_i;
    endtask
endmodule

// file: sim/peripheral_base_decode_test.sv
// Purpose: directed tests of the peripheral base decode
// Assumes: inputs change 1 ns after the rising edge
// Notes:   selects are combinational, sampled 10 ns after a change
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module peripheral_base_decode_test;
    import pbd_pkg::*;
    logic mclk_i = 0, rst_i = 1, write_i = 0, alt_master_i = 0, sram_hit_i = 0;
    logic ctl_wr_i, dbg_rd_i, dbg_sel_sec_i, sram_sel_o, pri_sel_o, sec_sel_o, ext_sel_o, sec_wins_o;
    logic [11:0] ctl_sel_i;
    logic [31:0] ctl_wdata_i, dbg_rdata_o, rd, addr_i = 0;
    logic [2:0]  pri_level_i = 0, sec_level_i = 0;
    logic [7:0]  ls = 8'hAB;
    pbd_space_e  space_i = PBD_SP_SUPER_DATA;
    int          fail_count = 0, n_compared = 0, cycles = 0;
    always #25 mclk_i = ~mclk_i;
    pbd_decode pbd_decode_i (.*);
    pbd_cpu_model pbd_cpu_model_i (.mclk_i, .ctl_wr_o(ctl_wr_i), .ctl_sel_o(ctl_sel_i),
        .ctl_wdata_o(ctl_wdata_i), .dbg_rd_o(dbg_rd_i), .dbg_sel_o(dbg_sel_sec_i),
        .dbg_rdata_i(dbg_rdata_o));
    task stop_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // hang guard, far above the hundred or so cycles the tests need
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 3000) begin fail_count++; stop_test(); end
    end
    task go(input logic [31:0] a, input pbd_space_e sp, input logic wr, alt);
        @(posedge mclk_i) #1;
        {addr_i, space_i, write_i, alt_master_i} = {a, sp, wr, alt};
        #10;
    endtask
    // one mask bit set, then a cycle with the given attributes
    task mask_case(input int b, input pbd_space_e sp, input logic alt, wr, hit);
        pbd_cpu_model_i.ctl_write(CTL_PRIMARY, 32'h1000_0001 | (32'h1 << b));
        go(32'h1000_0ABC, sp, wr, alt);
        `CHK(pri_sel_o, hit)
        `CHK(ext_sel_o, !hit)
    endtask
    initial begin
        repeat (20) @(posedge mclk_i);
        #1 rst_i = 0;
        pbd_cpu_model_i.dbg_read(0, rd); `CHK(rd, ZERO_WORD)
        pbd_cpu_model_i.dbg_read(1, rd); `CHK(rd, ZERO_WORD)
        go(32'h0, PBD_SP_SUPER_DATA, 0, 0); `CHK(ext_sel_o, 1'b1)
        $display("test reset done");
        pbd_cpu_model_i.ctl_write(12'h801, 32'hFFFF_FFFF);
        pbd_cpu_model_i.ctl_write(CTL_PRIMARY, 32'hFFFF_FFFF);
        pbd_cpu_model_i.dbg_read(0, rd); `CHK(rd, PRI_WR_MASK)
        pbd_cpu_model_i.dbg_read(1, rd); `CHK(rd, ZERO_WORD)
        pbd_cpu_model_i.ctl_write(CTL_PRIMARY, 32'h1000_0001);
        go(32'h1000_0FFF, PBD_SP_SUPER_DATA, 0, 0); `CHK(pri_sel_o, 1'b1)
        go(32'h1000_1000, PBD_SP_SUPER_DATA, 0, 0); `CHK(ext_sel_o, 1'b1)
        @(posedge mclk_i) #1 sram_hit_i = 1;
        go(32'h1000_0000, PBD_SP_SUPER_DATA, 0, 0); `CHK(sram_sel_o, 1'b1)
        `CHK(pri_sel_o, 1'b0)
        @(posedge mclk_i) #1 sram_hit_i = 0;
        $display("test base done");
        mask_case(PRI_SC_BIT, PBD_SP_SUPER_CODE, 0, 0, 0);
        mask_case(PRI_SD_BIT, PBD_SP_SUPER_DATA, 0, 0, 0);
        mask_case(PRI_UC_BIT, PBD_SP_USER_CODE, 0, 0, 0);
        mask_case(PRI_UD_BIT, PBD_SP_USER_DATA, 0, 0, 0);
        mask_case(PRI_UD_BIT, PBD_SP_USER_CODE, 0, 0, 1);
        mask_case(PRI_CI_BIT, PBD_SP_CPU, 0, 0, 0);
        mask_case(PRI_CI_BIT, PBD_SP_SUPER_DATA, 0, 0, 1);
        mask_case(PRI_WP_BIT, PBD_SP_SUPER_DATA, 0, 1, 0);
        mask_case(PRI_WP_BIT, PBD_SP_SUPER_DATA, 0, 0, 1);
        mask_case(PRI_AM_BIT, PBD_SP_SUPER_DATA, 1, 0, 0);
        mask_case(PRI_AM_BIT, PBD_SP_SUPER_DATA, 0, 0, 1);
        mask_case(PRI_SC_BIT, PBD_SP_SUPER_CODE, 1, 0, 1);
        $display("test masks done");
        pbd_cpu_model_i.ctl_write(CTL_SECONDARY, 32'h8000_00AA);
        go(32'h8000_0000, PBD_SP_SUPER_DATA, 0, 0); `CHK(sec_sel_o, 1'b0)
        pbd_cpu_model_i.ctl_write(CTL_SECONDARY, 32'hBFFF_FFAB);
        pbd_cpu_model_i.ctl_write(CTL_PRIMARY, 32'h8000_0001);
        go(32'hBFFF_FFFC, PBD_SP_SUPER_DATA, 0, 0); `CHK(sec_sel_o, 1'b1)
        go(32'h8000_0000, PBD_SP_SUPER_DATA, 0, 0); `CHK(pri_sel_o, 1'b0)
        go(32'hC000_0000, PBD_SP_SUPER_DATA, 0, 0); `CHK(sec_sel_o, 1'b0)
        pbd_cpu_model_i.dbg_read(1, rd); `CHK(rd, 32'h8000_00AB)
        for (int i = 1; i <= LEVELS; i++) begin
            @(posedge mclk_i) #1;
            {pri_level_i, sec_level_i} = {i[2:0], i[2:0]};
            #10 `CHK(sec_wins_o, ls[i])
        end
        @(posedge mclk_i) #1 {pri_level_i, sec_level_i} = {3'h3, 3'h5};
        #10 `CHK(sec_wins_o, 1'b1)
        @(posedge mclk_i) #1 {pri_level_i, sec_level_i} = {3'h6, 3'h2};
        #10 `CHK(sec_wins_o, 1'b0)
        $display("test secondary done");
        @(posedge mclk_i) #1 rst_i = 1;
        repeat (2) @(posedge mclk_i);
        #1 rst_i = 0;
        {pri_level_i, sec_level_i} = {3'h1, 3'h1};
        pbd_cpu_model_i.dbg_read(1, rd); `CHK(rd, ZERO_WORD)
        `CHK(sec_wins_o, 1'b0)
        go(32'h8000_0000, PBD_SP_SUPER_DATA, 0, 0); `CHK(ext_sel_o, 1'b1)
        $display("test second reset done");
        stop_test();
    end
endmodule
